// ### src/hppc_host_port.sv
// Host port pin control: strap, strobes, byte assembly, ready and interrupt pins
// Summary of operation
// - Byte-select marks first or second byte; device assembles 16-bit words from it.
// - Address strobe captures the address into the host address pointer.
// - Read/write picks direction; device drives data bus only on reads.
// - Ready output tells host whether the next transfer can be taken.
// - Host interrupt output signals host, held high during device reset.
// - With port disabled, interrupt pin may carry second timer output.
// - Enable strap sampled at reset release; high enables the port.
// - Strap low or floating during reset disables the port.
// - Once disabled, strap changes are ignored until the next reset.
// - Input pull-ups enabled only when strap was sampled at zero.
// - Ready and interrupt outputs float while output-float input is low.
// - Two access-select inputs choose one of four port registers.
// - Eight-bit two-way data bus, driven only while outputting read data.
`timescale 1ns/100ps
module hppc_host_port (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Host pins, asynchronous
    input  wire logic        port_enable_strap,
    input  wire logic        port_select_n,
    input  wire logic        data_strobe_a,
    input  wire logic        data_strobe_b,
    input  wire logic        address_strobe_n,
    input  wire logic        read_not_write,
    input  wire logic        byte_select,
    input  wire logic        access_select_0,
    input  wire logic        access_select_1,
    input  wire logic        output_float_n,
    // Host data bus as three signals
    input  wire logic [7:0]  host_data_in,
    output logic      [7:0]  host_data_out,
    output logic             host_data_oe,
    // Ready and interrupt pins
    output logic             port_ready,
    output logic             port_ready_oe,
    output logic             host_irq_out,
    output logic             host_irq_oe,
    // Pad control
    output logic             pullup_enable,
    output logic             port_enabled,
    // Core side
    input  wire logic        core_irq_req,
    input  wire logic        core_busy,
    input  wire logic        second_timer_out,
    input  wire logic [15:0] core_rd_word,
    output logic      [15:0] core_wr_word,
    output logic      [1:0]  core_reg_sel,
    output logic             core_wr_pulse,
    output logic             core_rd_pulse,
    output logic      [15:0] host_address_pointer
);

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers on every host pin
    localparam int NPIN = 18;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] meta_q;
    logic [NPIN-1:0] sync_q;
    logic [NPIN-1:0] meta_d;
    logic [NPIN-1:0] sync_d;
    assign pin_raw = {host_data_in, access_select_1, access_select_0, byte_select,
                      read_not_write, address_strobe_n, data_strobe_b, data_strobe_a,
                      port_select_n, port_enable_strap, output_float_n};

    always_comb begin
        meta_d = pin_raw;
        sync_d = meta_q;
    end

    always_ff @(posedge mclk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    logic       s_float_n;
    logic       s_strap;
    logic       s_cs_n;
    logic       s_ds_a;
    logic       s_ds_b;
    logic       s_as_n;
    logic       s_rnw;
    logic       s_bsel;
    logic [1:0] s_sel;
    logic [7:0] s_data;
    assign s_float_n = sync_q[0];
    assign s_strap = sync_q[1];
    assign s_cs_n = sync_q[2];
    assign s_ds_a = sync_q[3];
    assign s_ds_b = sync_q[4];
    assign s_as_n = sync_q[5];
    assign s_rnw = sync_q[6];
    assign s_bsel = sync_q[7];
    assign s_sel = sync_q[9:8];
    assign s_data = sync_q[17:10];

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture: tracked during reset, frozen at release
    logic strap_en_q;
    logic strap_en_d;

    always_comb begin
        if (sys_rst) begin
            strap_en_d = s_strap;
        end else begin
            strap_en_d = strap_en_q;
        end
    end

    always_ff @(posedge mclk) begin
        strap_en_q <= strap_en_d;
    end

    // Port counts as disabled while reset is asserted
    assign port_enabled = strap_en_q && !sys_rst;
    assign pullup_enable = !strap_en_q;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe handshake and word assembly
    logic strobe;
    logic strobe_q;
    logic as_n_q;
    assign strobe = !s_cs_n && !(s_ds_a && s_ds_b) && port_enabled;

    hppc_pkg::hppc_state_t state_q;
    hppc_pkg::hppc_state_t state_d;
    logic [7:0]  low_q;
    logic [7:0]  low_d;
    logic [15:0] wr_word_q;
    logic [15:0] wr_word_d;
    logic [15:0] hap_q;
    logic [15:0] hap_d;
    logic [7:0]  dout_q;
    logic [7:0]  dout_d;
    logic        wr_p_d;
    logic        rd_p_d;
    logic        wr_p_q;
    logic        rd_p_q;
    logic [1:0]  sel_q;
    logic [1:0]  sel_d;

    // A write completes the word on the second byte; a read fetches on the first
    always_comb begin
        state_d = state_q;
        low_d = low_q;
        wr_word_d = wr_word_q;
        hap_d = hap_q;
        dout_d = dout_q;
        wr_p_d = 1'b0;
        rd_p_d = 1'b0;
        sel_d = sel_q;
        // Multiplexed hosts latch the address on the rising edge of the strobe
        if (port_enabled && !s_cs_n && !as_n_q && s_as_n) begin
            hap_d = {hap_q[7:0], s_data};
        end
        case (state_q)
            hppc_pkg::HPPC_IDLE: begin
                if (strobe && !strobe_q) begin
                    sel_d = s_sel;
                    state_d = hppc_pkg::HPPC_BUSY;
                    if (s_rnw) begin
                        dout_d = (s_bsel == hppc_pkg::BYTE_FIRST) ? core_rd_word[15:8]
                                                                  : core_rd_word[7:0];
                        rd_p_d = (s_bsel == hppc_pkg::BYTE_FIRST);
                    end
                end
            end
            hppc_pkg::HPPC_BUSY: begin
                if (!strobe) begin
                    state_d = hppc_pkg::HPPC_DONE;
                    if (!s_rnw) begin
                        if (s_bsel == hppc_pkg::BYTE_FIRST) begin
                            low_d = s_data;
                        end else begin
                            wr_word_d = {low_q, s_data};
                            if (sel_q == hppc_pkg::SEL_ADDR) begin
                                hap_d = {low_q, s_data};
                            end else begin
                                wr_p_d = 1'b1;
                            end
                        end
                    end
                end
            end
            hppc_pkg::HPPC_DONE: begin
                state_d = hppc_pkg::HPPC_IDLE;
            end
            default: begin
                state_d = hppc_pkg::HPPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= hppc_pkg::HPPC_IDLE;
            strobe_q <= 1'b0;
            as_n_q <= 1'b1;
            low_q <= hppc_pkg::BYTE_RST;
            wr_word_q <= hppc_pkg::WORD_RST;
            hap_q <= hppc_pkg::WORD_RST;
            dout_q <= hppc_pkg::BYTE_RST;
            wr_p_q <= 1'b0;
            rd_p_q <= 1'b0;
            sel_q <= hppc_pkg::SEL_CTRL;
        end else begin
            state_q <= state_d;
            strobe_q <= strobe;
            as_n_q <= s_as_n;
            low_q <= low_d;
            wr_word_q <= wr_word_d;
            hap_q <= hap_d;
            dout_q <= dout_d;
            wr_p_q <= wr_p_d;
            rd_p_q <= rd_p_d;
            sel_q <= sel_d;
        end
    end

    assign core_wr_word = wr_word_q;
    assign core_reg_sel = sel_q;
    assign core_wr_pulse = wr_p_q;
    assign core_rd_pulse = rd_p_q;
    assign host_address_pointer = hap_q;
    assign host_data_out = dout_q;
    // Driven only inside a read strobe; released as soon as it ends
    assign host_data_oe = strobe && s_rnw && (state_q == hppc_pkg::HPPC_BUSY);

    ////////////////////////////////////////////////////////////////////////////
    // Ready and interrupt pins
    // Not ready while a strobe is in flight or the core is busy
    assign port_ready = port_enabled && !core_busy
                        && (state_q == hppc_pkg::HPPC_IDLE);
    assign port_ready_oe = s_float_n;
    // Interrupt active low; high in reset, timer output when disabled
    always_comb begin
        if (sys_rst) begin
            host_irq_out = 1'b1;
        end else if (!strap_en_q) begin
            host_irq_out = second_timer_out;
        end else begin
            host_irq_out = !core_irq_req;
        end
    end
    assign host_irq_oe = s_float_n;

endmodule

// ### src/hppc_pkg.sv
// Package: constants and types of the host port pin control block
package hppc_pkg;
    // Access select codes: one of four port registers
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_DATA_INC = 2'h1;
    localparam logic [1:0] SEL_ADDR = 2'h2;
    localparam logic [1:0] SEL_DATA = 2'h3;
    // Byte identifier levels
    localparam logic BYTE_FIRST = 1'h0;
    localparam logic BYTE_SECOND = 1'h1;
    // Reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Strobe handshake states
    typedef enum logic [1:0] {
        HPPC_IDLE = 2'b00,
        HPPC_BUSY = 2'b01,
        HPPC_DONE = 2'b10
    } hppc_state_t;
endpackage

// ### tb/host_port_pin_control_tb.sv
// Testbench of the host port pin control block
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module host_port_pin_control_tb;
    logic mclk = 0, sys_rst = 1, strap = 1, ofl_n = 1, cirq = 0, tmr = 0, busy = 0;
    logic csn, dsa, dsb, asn, rw, bs, hden, oe, rdy, roe, irq, ioe, pue, pen, wp, rp;
    logic [1:0] asel, rsel;
    logic [7:0] hdo, dout, q, wr_n = 0, rd_n = 0;
    logic [15:0] rdw = 0, ww, ptr, wr_w;
    logic [1:0] wr_s;
    wire [7:0] hd = oe ? dout : (hden ? hdo : ~hdo);
    initial forever #50 mclk = ~mclk;
    // Capture of core write pulses
    always @(posedge mclk) if (wp) {wr_n, wr_w, wr_s} <= {wr_n + 8'h1, ww, rsel};
    // Count of core read pulses
    always @(posedge mclk) if (rp) rd_n <= rd_n + 8'h1;
    hppc_host_port u_dut (.mclk(mclk), .sys_rst(sys_rst), .port_enable_strap(strap),
        .port_select_n(csn), .data_strobe_a(dsa), .data_strobe_b(dsb), .address_strobe_n(asn),
        .read_not_write(rw), .byte_select(bs), .access_select_0(asel[0]),
        .access_select_1(asel[1]), .output_float_n(ofl_n), .host_data_in(hd),
        .host_data_out(dout), .host_data_oe(oe), .port_ready(rdy), .port_ready_oe(roe),
        .host_irq_out(irq), .host_irq_oe(ioe), .pullup_enable(pue), .port_enabled(pen),
        .core_irq_req(cirq), .core_busy(busy), .second_timer_out(tmr), .core_rd_word(rdw),
        .core_wr_word(ww), .core_reg_sel(rsel), .core_wr_pulse(wp), .core_rd_pulse(rp),
        .host_address_pointer(ptr));
    hppc_host_model u_host (.mclk(mclk), .port_ready(rdy), .bus(hd), .port_select_n(csn),
        .data_strobe_a(dsa), .data_strobe_b(dsb), .address_strobe_n(asn),
        .read_not_write(rw), .byte_select(bs), .acc_sel(asel), .hd_en(hden), .hd_o(hdo));
    int miscompares = 0, total_checks = 0;
    task automatic final_report();
        if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Reset with a given strap level, sampled as reset ends
    task automatic do_reset(input logic s);
        @(posedge mclk) #1 {sys_rst, strap} = {1'h1, s};
        repeat (4) @(posedge mclk);
        `CHK(irq, 1'h1)
        #1 sys_rst = 1'h0;
        repeat (2) @(posedge mclk);
        `CHK({pen, pue}, {s, !s})
    endtask
    // Two-byte writes for the control, data-increment and data selects; the address select is left to t_addr
    task automatic t_write();
        logic [1:0] sels [3] = '{hppc_pkg::SEL_CTRL, hppc_pkg::SEL_DATA_INC, hppc_pkg::SEL_DATA};
        for (int i = 0; i < 3; i++) begin
            u_host.xfer(1'h0, 1'h0, hppc_pkg::BYTE_FIRST, sels[i], 8'ha0 + 8'(i), q);
            u_host.xfer(1'h0, 1'h0, hppc_pkg::BYTE_SECOND, sels[i], 8'h5c, q);
            `CHK({wr_n, wr_w, wr_s}, {8'(i + 1), 8'ha0 + 8'(i), 8'h5c, sels[i]})
        end
    endtask
    // Pointer by address strobe, then by register write
    task automatic t_addr();
        u_host.addr(8'h12);
        u_host.addr(8'h34);
        `CHK(ptr, 16'h1234)
        u_host.xfer(1'h0, 1'h0, hppc_pkg::BYTE_FIRST, hppc_pkg::SEL_ADDR, 8'hbe, q);
        u_host.xfer(1'h0, 1'h0, hppc_pkg::BYTE_SECOND, hppc_pkg::SEL_ADDR, 8'hef, q);
        `CHK({ptr, wr_n}, {16'hbeef, 8'h3})
    endtask
    // Read halves, then a deselected strobe that must do nothing
    task automatic t_read();
        rdw = 16'hc3a5;
        u_host.xfer(1'h0, 1'h1, hppc_pkg::BYTE_FIRST, hppc_pkg::SEL_DATA, 8'h00, q);
        `CHK({q, rd_n}, {8'hc3, 8'h1})
        u_host.xfer(1'h0, 1'h1, hppc_pkg::BYTE_SECOND, hppc_pkg::SEL_DATA, 8'h00, q);
        `CHK({q, rd_n}, {8'ha5, 8'h1})
        u_host.xfer(1'h1, 1'h0, hppc_pkg::BYTE_SECOND, hppc_pkg::SEL_DATA, 8'h77, q);
        // Long enough for a wrongly taken write to show its pulse
        repeat (4) @(posedge mclk);
        #1;
        `CHK({wr_n, rdy, u_host.stalls}, {8'h3, 1'h1, 32'h0})
    endtask
    // Interrupt levels, core busy, and floating of ready and interrupt
    task automatic t_float();
        @(posedge mclk) #1 {cirq, ofl_n, busy} = 3'h5;
        repeat (4) @(posedge mclk);
        `CHK({irq, roe, ioe, rdy}, 4'h0)
        #1 {cirq, ofl_n, busy} = 3'h2;
        repeat (4) @(posedge mclk);
        `CHK({irq, roe, ioe, rdy}, 4'hf)
    endtask
    // Disabled port: timer on irq pin, strap and strobes ignored
    task automatic t_dis();
        do_reset(1'h0);
        #1 {tmr, strap} = 2'h3;
        repeat (4) @(posedge mclk);
        `CHK({irq, pen}, 2'h2)
        // Disabled port never shows ready, so the host's wait runs out once
        u_host.xfer(1'h0, 1'h0, hppc_pkg::BYTE_SECOND, hppc_pkg::SEL_DATA, 8'h99, q);
        `CHK({irq, wr_n, pen, rdy, u_host.stalls}, {1'h1, 8'h3, 1'h0, 1'h0, 32'h1})
    endtask
    // Watchdog
    initial begin
        #(100 * 3000);
        miscompares++;
        final_report();
    end
    initial begin
        do_reset(1'h1);
        t_write();
        t_addr();
        t_read();
        t_float();
        t_dis();
        final_report();
    end
endmodule

// ### tb/hppc_host_model.sv
// Host processor model on the strobe side of the port
`timescale 1ns/100ps
module hppc_host_model (
    // Clock and port answers
    input wire logic       mclk,
    input wire logic       port_ready,
    input wire logic [7:0] bus,
    // Host pins
    output logic           port_select_n,
    output logic           data_strobe_a,
    output logic           data_strobe_b,
    output logic           address_strobe_n,
    output logic           read_not_write,
    output logic           byte_select,
    output logic [1:0]     acc_sel,
    output logic           hd_en,
    output logic [7:0]     hd_o
);
    // Ready waits that ran out; the bench judges this count
    int stalls = 0;
    // Idle: deselected, strobes high
    initial {port_select_n, data_strobe_a, data_strobe_b, address_strobe_n, hd_en} = 5'h1e;
    initial {read_not_write, byte_select, acc_sel, hd_o} = 12'h0;
    // One byte strobe; releases the strobe, then waits on ready before releasing select
    task automatic xfer(input logic cs, input logic rw, input logic bs,
                        input logic [1:0] sel, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge mclk) #1;
        {port_select_n, read_not_write, byte_select, acc_sel} = {cs, rw, bs, sel};
        {hd_en, hd_o} = {!rw, d};
        {data_strobe_a, data_strobe_b} = bs ? 2'h1 : 2'h2;
        repeat (6) @(posedge mclk);
        q = bus;
        #1 {data_strobe_a, data_strobe_b} = 2'h3;
        // Ready looked at off the edge, never in the step that launches it
        for (n = 0; n < 20 && port_ready !== 1'h1; n++) @(posedge mclk) #1;
        if (n == 20) stalls++;
        @(posedge mclk) #1 {port_select_n, hd_en} = 2'h2;
    endtask
    // Multiplexed address byte on the address strobe, select held throughout
    task automatic addr(input logic [7:0] d);
        @(posedge mclk) #1;
        {port_select_n, hd_en, hd_o, address_strobe_n} = {1'h0, 1'h1, d, 1'h0};
        repeat (4) @(posedge mclk);
        #1 address_strobe_n = 1'h1;
        repeat (4) @(posedge mclk);
        #1 {port_select_n, hd_en} = 2'h2;
    endtask
endmodule

// ### tb/hppc_host_port_props.sv
// Checker of the host port pin control block
`timescale 1ns/100ps
module hppc_host_port_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Watched pins
    input wire logic port_select_n,
    input wire logic output_float_n,
    input wire logic read_not_write,
    input wire logic second_timer_out,
    input wire logic core_irq_req,
    input wire logic host_data_oe,
    input wire logic port_ready_oe,
    input wire logic host_irq_out,
    input wire logic host_irq_oe,
    input wire logic pullup_enable,
    input wire logic port_enabled,
    input wire logic core_wr_pulse,
    input wire logic core_rd_pulse,
    input wire logic port_ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Reset forces the interrupt pin high
    AST_IRQ_RST: assert property (disable iff (1'h0) sys_rst |-> host_irq_out)
        else $error("irq low in reset");
    AST_IRQ_CORE: assert property (port_enabled |-> host_irq_out == !core_irq_req)
        else $error("irq not from core");
    AST_IRQ_TMR: assert property (!port_enabled |-> host_irq_out == second_timer_out)
        else $error("irq not timer");
    // Sync lag of two flops covered by three low samples
    AST_FLOAT: assert property (!output_float_n [*3] |-> !port_ready_oe && !host_irq_oe)
        else $error("pins driven while float");
    AST_PULLUP: assert property (pullup_enable == !port_enabled)
        else $error("pullup mismatch");
    AST_STRAP_HOLD: assert property (!$past(sys_rst) |-> $stable(port_enabled))
        else $error("enable moved after reset");
    AST_DIS_QUIET: assert property (!port_enabled |-> !core_wr_pulse && !core_rd_pulse)
        else $error("access while disabled");
    AST_READ_OE: assert property (host_data_oe |-> port_enabled && $past(read_not_write, 2))
        else $error("bus driven on write");
    AST_CS_IGN: assert property (port_select_n [*8] |-> !core_wr_pulse && !core_rd_pulse)
        else $error("access without select");
    // Core pulses only fall inside a transfer, while ready is low
    AST_PULSE_RDY: assert property (core_wr_pulse || core_rd_pulse |-> !port_ready)
        else $error("ready during transfer");
    AST_WR_ONE: assert property (core_wr_pulse |=> !core_wr_pulse)
        else $error("write pulse too long");
endmodule
bind hppc_host_port hppc_host_port_props u_props (.*);
